// *** logic/smii_phy_port.sv ***
/*
 * Device end of the serial segment port: deserialises the transmit line, serialises
 * the receive line and keeps an APB register pair for status and control.
 * Assumes the reference clock and sync come from the MAC and run without pause,
 * and that the byte streams on the user side are on clk.
 */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
// Notes on behaviour
// - Each sync starts a ten-bit segment.
// - Slow rate: transmit segments repeat ten times.
// - Fast rate: every segment carries a fresh byte.
// - Slow rate: receive segments sent ten times.
// - Enable low means status bits, else data.
// - Receive segment: carrier, valid, eight data bits.
// - Valid low means status bits, else data.
// - Clock, sync, transmit in; receive out.
`timescale 1ns/1ps
module smii_phy_port (
   // System clock and synchronous reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Mode strap pins.
   input  wire logic [2:0]  mode_strap,
   // Receive bytes from the line coder, toward the MAC.
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_byte_valid,
   output logic             rx_byte_ready,
   // Transmit bytes from the MAC, toward the line coder.
   output logic      [7:0]  tx_byte,
   output logic             tx_byte_err,
   output logic             tx_byte_valid,
   // Serial link on the reference clock.
   input  wire logic        link_clk,
   input  wire logic        sync_in,
   input  wire logic        tx_in,
   output logic             rx_out
);
   // Register and clk-side state.
   logic [31:0] ctrl, next_ctrl;                   // Control register.
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   logic [2:0]  strap_meta, strap_sync;            // Strap synchroniser.
   logic        mode, next_mode;                   // Serial mode selected.
   logic [7:0]  rx_hold, next_rx_hold;             // Byte offered to the link.
   logic        rx_req, next_rx_req;               // Toggles once per offered byte.
   logic        ack_meta, ack_sync;                // Link acknowledge, synchronised.
   logic        next_rx_ready;
   logic [2:0]  tgl_sync;                          // Transmit toggle synchroniser and edge.
   logic [7:0]  mac_stat, next_mac_stat;           // Last in-band status from the MAC.
   logic [7:0]  next_tx_byte;
   logic        next_tx_err, next_tx_valid;

   // Link-side state.
   logic                  lrst_meta, lrst;          // Reset carried onto the link clock.
   logic [8:0]            cfg_meta, cfg;            // Control byte and mode, synchronised.
   logic                  req_meta, req_sync;       // Offer toggle, synchronised.
   logic [3:0]            cnt, next_cnt;            // Bits seen in the current segment.
   logic [3:0]            rep, next_rep;            // Repeat number at the slow rate.
   logic [9:0]            seg, next_seg;            // Receive segment being sent.
   logic                  next_rx_out;
   logic                  ack, next_ack;            // Acknowledge toggle.
   logic [9:0]            tx_sh, next_tx_sh;        // Transmit shift register.
   smii_pkg::smii_tx_seg_t tx_word, next_tx_word;   // Last captured segment.
   logic                  tx_tgl, next_tx_tgl;      // Toggles per captured segment.

   // Combinational view of the link clock edge.
   logic [3:0]            idx;                      // Bit index sampled at this edge.
   logic                  aligned, seg_end, fwd, take, l_speed, l_mode;
   logic [9:0]            new_seg;
   smii_pkg::smii_rx_stat_t st;

   // Register access, strap capture and byte handoff on the system clock.
   always_comb begin
      next_ctrl     = ctrl;
      next_pready   = psel && !penable && !pready;
      next_pslverr  = 1'b0;
      next_prdata   = 32'h0000_0000;
      // Setup cycle: decide the answer, so pready comes from a flop in the access cycle.
      if (psel && !penable) begin
         case (paddr)
            smii_pkg::ADDR_CTRL: next_prdata = ctrl;
            smii_pkg::ADDR_STAT: begin
               next_prdata[smii_pkg::STAT_MAC_LSB +: 8] = mac_stat;
               next_prdata[smii_pkg::STAT_MODE]         = mode;
               next_prdata[smii_pkg::STAT_BUSY]         = ack_sync != rx_req;
            end
            default: next_pslverr = 1'b1;         // Unmapped offsets answer with an error.
         endcase
         if (pwrite && paddr == smii_pkg::ADDR_STAT) begin
            next_pslverr = 1'b1;                  // Status is read only.
         end
      end
      // A write takes effect in the completing access cycle.
      if (psel && penable && pready && pwrite && paddr == smii_pkg::ADDR_CTRL) begin
         next_ctrl = {24'h00_0000, pwdata[7:0]};
      end
      // Mode is judged from the strap while reset is held and frozen afterwards.
      next_mode = rst ? (strap_sync == smii_pkg::STRAP_SERIAL) : mode;
      // A new receive byte is accepted only once the link took the previous one.
      next_rx_hold  = rx_hold;
      next_rx_req   = rx_req;
      next_rx_ready = ack_sync == rx_req;
      if (rx_byte_valid && rx_byte_ready) begin
         next_rx_hold  = rx_byte;
         next_rx_req   = !rx_req;
         next_rx_ready = 1'b0;
      end
      // A transmit segment arrives as a toggle; its word is stable for a whole segment.
      next_tx_valid = 1'b0;
      next_tx_byte  = tx_byte;
      next_tx_err   = tx_byte_err;
      next_mac_stat = mac_stat;
      if (tgl_sync[1] != tgl_sync[2]) begin
         if (tx_word.en) begin
            next_tx_byte  = tx_word.data;
            next_tx_err   = tx_word.er;
            next_tx_valid = 1'b1;
         end else begin
            next_mac_stat = tx_word.data;
         end
      end
   end

   // Registers of the system clock; synchroniser stages hold no reset.
   always_ff @(posedge clk) begin
      strap_meta <= mode_strap;
      strap_sync <= strap_meta;
      ack_meta   <= ack;
      ack_sync   <= ack_meta;
      tgl_sync   <= {tgl_sync[1:0], tx_tgl};
      mode       <= next_mode;
      if (rst) begin
         ctrl          <= smii_pkg::CTRL_RESET;
         prdata        <= 32'h0000_0000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         rx_hold       <= 8'h00;
         rx_req        <= 1'b0;
         rx_byte_ready <= 1'b0;
         mac_stat      <= 8'h00;
         tx_byte       <= 8'h00;
         tx_byte_err   <= 1'b0;
         tx_byte_valid <= 1'b0;
      end else begin
         ctrl          <= next_ctrl;
         prdata        <= next_prdata;
         pready        <= next_pready;
         pslverr       <= next_pslverr;
         rx_hold       <= next_rx_hold;
         rx_req        <= next_rx_req;
         rx_byte_ready <= next_rx_ready;
         mac_stat      <= next_mac_stat;
         tx_byte       <= next_tx_byte;
         tx_byte_err   <= next_tx_err;
         tx_byte_valid <= next_tx_valid;
      end
   end

   // Segment timing on the reference clock, which the MAC keeps running.
   always_comb begin
      l_speed = cfg[smii_pkg::CTRL_SPEED];
      l_mode  = cfg[8];
      st      = smii_pkg::smii_rx_stat_t'(cfg[7:0]);
      idx     = sync_in ? 4'h0 : cnt;
      aligned = sync_in || cnt <= smii_pkg::SEG_LAST;
      seg_end = aligned && idx == smii_pkg::SEG_LAST;
      fwd     = l_speed || rep == 4'h0;
      take    = seg_end && fwd && l_mode && req_sync != ack;
      next_cnt = seg_end || !aligned ? smii_pkg::SEG_NONE : 4'(idx + 4'h1);
      next_rep = rep;
      if (seg_end) begin
         next_rep = rep == smii_pkg::REP_LAST ? 4'h0 : 4'(rep + 4'h1);
      end
      // Transmit bits arrive error first, so after ten shifts bit 0 holds the error flag.
      next_tx_sh   = {tx_in, tx_sh[9:1]};
      next_tx_word = tx_word;
      next_tx_tgl  = tx_tgl;
      if (seg_end && fwd && l_mode) begin
         next_tx_word = smii_pkg::smii_tx_seg_t'({next_tx_sh[9:2], next_tx_sh[1], next_tx_sh[0]});
         next_tx_tgl  = !tx_tgl;
      end
      // Build the next receive segment: carrier first, valid, then the byte from bit 0.
      if (take) begin
         new_seg = {rx_hold, 1'b1, 1'b1};
      end else begin
         new_seg = {1'b1, st.false_carrier, st.nibble_ok, st.jabber, st.link, st.duplex,
                    st.speed, st.rx_err_prev, 1'b0, st.carrier};
      end
      next_ack = take ? !ack : ack;
      // Slow-rate segments other than the first repeat resend the held segment.
      next_seg = seg_end && fwd ? new_seg : seg;
      // The bit driven now is sampled at the next edge, so the first bit goes out early.
      next_rx_out = 1'b0;
      if (aligned && l_mode) begin
         next_rx_out = seg_end ? next_seg[0] : seg[4'(idx + 4'h1)];
      end
   end

   // Registers of the reference clock; reset arrives through its own synchroniser.
   always_ff @(posedge link_clk) begin
      lrst_meta <= rst;
      lrst      <= lrst_meta;
      cfg_meta  <= {mode, ctrl[7:0]};
      cfg       <= cfg_meta;
      req_meta  <= rx_req;
      req_sync  <= req_meta;
      tx_sh     <= next_tx_sh;
      if (lrst) begin
         cnt     <= smii_pkg::SEG_NONE;
         rep     <= 4'h0;
         seg     <= 10'h000;
         rx_out  <= 1'b0;
         ack     <= 1'b0;
         tx_word <= '0;
         tx_tgl  <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         rep     <= next_rep;
         seg     <= next_seg;
         rx_out  <= next_rx_out;
         ack     <= next_ack;
         tx_word <= next_tx_word;
         tx_tgl  <= next_tx_tgl;
      end
   end

   // Checks on the link clock.
   property p_seg_align;
      @(posedge link_clk) disable iff (lrst) sync_in |=> cnt == 4'h1;
   endproperty
   a_seg_align: assert property (p_seg_align) else $error("sync did not restart segment");

   property p_rx_first;
      @(posedge link_clk) disable iff (lrst) (seg_end && l_mode) |=> rx_out == seg[0];
   endproperty
   a_rx_first: assert property (p_rx_first) else $error("carrier bit not first");

   property p_rx_data;
      @(posedge link_clk) disable iff (lrst) take |=> seg[9:2] == $past(rx_hold) && seg[1];
   endproperty
   a_rx_data: assert property (p_rx_data) else $error("data segment wrong");

   property p_rx_stat;
      @(posedge link_clk) disable iff (lrst)
         (seg_end && fwd && !take) |=> seg[9] && !seg[1];
   endproperty
   a_rx_stat: assert property (p_rx_stat) else $error("status segment wrong");

   property p_rx_repeat;
      @(posedge link_clk) disable iff (lrst)
         (seg_end && !l_speed && rep != 4'h0) |=> seg == $past(seg);
   endproperty
   a_rx_repeat: assert property (p_rx_repeat) else $error("slow segment not repeated");

   property p_fresh;
      @(posedge link_clk) disable iff (lrst)
         (seg_end && l_speed && l_mode && req_sync != ack) |=> ack != $past(ack);
   endproperty
   a_fresh: assert property (p_fresh) else $error("fast byte not taken");

   property p_tx_rep;
      @(posedge link_clk) disable iff (lrst)
         (seg_end && !l_speed && rep != 4'h0) |=> tx_tgl == $past(tx_tgl);
   endproperty
   a_tx_rep: assert property (p_tx_rep) else $error("slow repeat captured");

   property p_tx_cap;
      @(posedge link_clk) disable iff (lrst)
         (seg_end && fwd && l_mode) |=> tx_word.er == $past(tx_sh[1]) && tx_tgl != $past(tx_tgl);
   endproperty
   a_tx_cap: assert property (p_tx_cap) else $error("transmit capture wrong");

   // Checks on the system clock.
   property p_apb_wait;
      @(posedge clk) disable iff (rst) (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

   property p_tx_pulse;
      @(posedge clk) disable iff (rst) tx_byte_valid |=> !tx_byte_valid;
   endproperty
   a_tx_pulse: assert property (p_tx_pulse) else $error("transmit valid too long");

   c_rx_data:  cover property (@(posedge link_clk) disable iff (lrst) take);
   c_tx_data:  cover property (@(posedge clk) disable iff (rst) tx_byte_valid);
   c_slow_rep: cover property (@(posedge link_clk) disable iff (lrst)
                               seg_end && !l_speed && rep == smii_pkg::REP_LAST);
endmodule : smii_phy_port

// *** logic/smii_pkg.sv ***
/*
 * Shared constants and carrier types for the serial segment port.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
package smii_pkg;
   // Segment geometry: ten bits per segment, ten repeats of a segment at the slow rate.
   localparam logic [3:0] SEG_LAST  = 4'h9;    // Index of the last bit of a segment.
   localparam logic [3:0] SEG_NONE  = 4'hA;    // Counter value from reset or the end of a segment until the next sync.
   localparam logic [3:0] REP_LAST  = 4'h9;    // Last repeat of a slow-rate segment.

   // Strap value that selects the serial port at reset.
   localparam logic [2:0] STRAP_SERIAL = 3'h2;

   // Register byte offsets.
   localparam logic [11:0] ADDR_CTRL = 12'h000; // Control, read and write.
   localparam logic [11:0] ADDR_STAT = 12'h004; // Status, read only.

   // Control register fields and reset value.
   localparam int CTRL_SPEED   = 0;            // 1 selects the fast rate.
   localparam int CTRL_DUPLEX  = 1;            // 1 reports full duplex.
   localparam int CTRL_LINK    = 2;            // 1 reports link up.
   localparam int CTRL_JABBER  = 3;            // 1 reports jabber.
   localparam int CTRL_NIBBLE  = 4;            // 1 reports upper nibble valid.
   localparam int CTRL_FALSE   = 5;            // 1 reports a false carrier.
   localparam int CTRL_RXERR   = 6;            // 1 reports an error in the previous frame.
   localparam int CTRL_CARRIER = 7;            // Carrier sense shown in idle segments.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Status register fields.
   localparam int STAT_MAC_LSB = 0;            // Last status byte from the MAC, eight bits.
   localparam int STAT_MODE    = 8;            // Serial mode selected by the strap.
   localparam int STAT_BUSY    = 9;            // A receive byte awaits the link.

   // One decoded segment from the transmit line.
   typedef struct packed {
      logic [7:0] data;                        // Data byte or in-band status.
      logic       en;                          // Transmit enable.
      logic       er;                          // Transmit error.
   } smii_tx_seg_t;

   // Idle-time status carried on the receive line.
   typedef struct packed {
      logic       carrier;
      logic       rx_err_prev;
      logic       false_carrier;
      logic       nibble_ok;
      logic       jabber;
      logic       link;
      logic       duplex;
      logic       speed;
   } smii_rx_stat_t;
endpackage : smii_pkg

// *** sim/smii_mac_model.sv ***
/*
 * Behavioural MAC at the far side of the serial segment port.
 * Assumes the bench hands it the segment to send and reads back the last
 * segment that the device returned; the link clock runs free from time zero.
 */
`timescale 1ns/1ps
module smii_mac_model (
   // Segment to send and the last segment received.
   input  smii_pkg::smii_tx_seg_t tx_seg,
   output logic [9:0]             rx_last,
   output int                     seg_n,
   output logic                   col,
   // Serial link toward the device.
   output logic                   link_clk,
   output logic                   sync_in,
   output logic                   tx_in,
   input  wire logic              rx_out
);
   logic [3:0] pos;     // Index of the bit now on the lines.
   logic [9:0] tx_bits; // Segment being shifted out, error flag first.
   logic [9:0] rx_bits; // Segment being gathered from the device.

   // The reference clock never pauses, so it starts with an odd phase offset.
   initial begin
      {sync_in, tx_in, tx_bits, rx_bits, rx_last} = '0;
      pos = 4'h9;
      seg_n = 0;
      link_clk = 1'h0;
      #7;
      forever #80 link_clk = ~link_clk;
   end

   // Every tenth edge starts a segment and raises sync with its first bit.
   always @(posedge link_clk) begin
      rx_bits[pos] <= rx_out;
      if (pos == 4'h9) begin
         rx_last <= {rx_out, rx_bits[8:0]};
         seg_n <= seg_n + 1;
         tx_bits <= {tx_seg.data, tx_seg.en, tx_seg.er};
         tx_in <= tx_seg.er;
         sync_in <= 1'h1;
         pos <= 4'h0;
      end else begin
         tx_in <= tx_bits[pos + 4'h1];
         sync_in <= 1'h0;
         pos <= pos + 4'h1;
      end
   end

   // No collision line exists, so the MAC rebuilds it itself.
   assign col = rx_bits[0] & tx_bits[1];
endmodule : smii_mac_model

// *** sim/smii_phy_segment_port_bench.sv ***
/*
 * Self-checking bench for the device end of the serial segment port.
 * Assumes the package, the design and the MAC model are compiled first.
 */
`timescale 1ns/1ps
module smii_phy_segment_port_bench;
   logic        clk = 1'h0, rst = 1'h1, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        rx_byte_valid, rx_byte_ready, tx_byte_err, tx_byte_valid, slv, e;
   logic [7:0]  rx_byte, tx_byte, b, c;
   logic        link_clk, sync_in, tx_in, rx_out, col;
   logic [9:0]  rx_last;
   logic [2:0]  strap = 3'h2; // Strap pins; 010 selects the serial port.
   int          seg_n, errors = 0, n_checks = 0, cyc = 0;
   smii_pkg::smii_tx_seg_t tx_seg;
   logic [8:0]  txq[$]; // Transmit bytes seen, error flag on top.
   logic [9:0]  rxq[$]; // Receive segments that carried data.
   logic [8:0]  exq[$]; // Bytes expected, in order.

   smii_phy_port smii_phy_port_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mode_strap(strap), .rx_byte, .rx_byte_valid,
      .rx_byte_ready, .tx_byte, .tx_byte_err, .tx_byte_valid, .link_clk, .sync_in,
      .tx_in, .rx_out);
   smii_mac_model smii_mac_model_i (.tx_seg, .rx_last, .seg_n, .col, .link_clk,
      .sync_in, .tx_in, .rx_out);

   // System clock at 25 MHz.
   always #20 clk = ~clk;

   // Gather transmit bytes and cut a hang short.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_byte_valid === 1'h1)
         txq.push_back({tx_byte_err, tx_byte});
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end

   // Keep only segments marked valid; status segments are checked apart.
   always @(seg_n)
      if (rx_last[1] === 1'h1)
         rxq.push_back(rx_last);

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; waits for pready, then takes data and response.
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // Segment boundaries are seen on the link, then realigned to clk.
   task automatic segs(int n);
      repeat (n) @(seg_n);
      @(posedge clk);
   endtask : segs

   // Valid stays up between bytes so no step assigns it twice.
   task automatic rx_send(int n);
      repeat (n) begin
         b = 8'($urandom);
         exq.push_back({1'h0, b});
         rx_byte <= b;
         rx_byte_valid <= 1'h1;
         do @(posedge clk); while (rx_byte_ready !== 1'h1);
      end
      rx_byte_valid <= 1'h0;
   endtask : rx_send

   task automatic rx_cmp(int rep);
      check("rx count", rxq.size(), exq.size() * rep);
      foreach (rxq[i]) check("rx seg", rxq[i], {exq[i / rep][7:0], 2'h3});
      rxq.delete();
      exq.delete();
   endtask : rx_cmp

   // Each byte stays on the line for rep segments, then idle status follows.
   task automatic tx_send(int n, int rep);
      repeat (n) begin
         b = 8'($urandom);
         e = 1'($urandom);
         exq.push_back({e, b});
         tx_seg <= {b, 1'h1, e};
         segs(rep);
         // Idle carrier is set in the fast run and clear in the slow one.
         check("col", col, rep == 1);
      end
      tx_seg <= {8'hff, 2'h0};
      segs(3);
      check("tx count", txq.size(), exq.size());
      foreach (txq[i]) check("tx byte", txq[i], exq[i]);
      txq.delete();
      exq.delete();
   endtask : tx_send

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   initial begin
      {psel, penable, pwrite, paddr, pwdata, rx_byte, rx_byte_valid} = '0;
      tx_seg = {8'hff, 2'h0};
      void'($urandom(32'hea25_95e3));
      // The link reset needs a few link edges, so reset is held for sixteen cycles.
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      apb(1'h0, smii_pkg::ADDR_CTRL, 32'h0000_0000);
      check("ctrl reset", rd, smii_pkg::CTRL_RESET);
      apb(1'h0, smii_pkg::ADDR_STAT, 32'h0000_0000);
      check("mode", rd[8], 1'h1);
      apb(1'h1, smii_pkg::ADDR_STAT, 32'hffff_ffff);
      check("stat write err", slv, 1'h1);
      apb(1'h0, 12'h008, 32'h0000_0000);
      check("unmapped err", slv, 1'h1);
      check("unmapped data", rd, 32'h0000_0000);
      // Idle status on the receive line follows the control byte.
      for (int i = 0; i < 3; i++) begin
         // The last pass leaves carrier set, which the fast transmit run relies on.
         c = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : 8'($urandom) | 8'h81;
         apb(1'h1, smii_pkg::ADDR_CTRL, {24'h00_0000, c});
         apb(1'h0, smii_pkg::ADDR_CTRL, 32'h0000_0000);
         check("ctrl", rd, {24'h00_0000, c});
         segs(3);
         check("idle rx", rx_last, {1'h1, c[5:0], c[6], 1'h0, c[7]});
      end
      // A status segment from the MAC updates status, not the byte stream.
      c = {3'h7, 5'($urandom)};
      tx_seg <= {c, 2'h0};
      segs(3);
      apb(1'h0, smii_pkg::ADDR_STAT, 32'h0000_0000);
      check("mac status", rd[7:0], c);
      check("no tx byte", txq.size(), 0);
      tx_send(8, 1);
      rx_send(6);
      segs(4);
      rx_cmp(1);
      // Slow rate: every byte spans ten segments both ways.
      apb(1'h1, smii_pkg::ADDR_CTRL, 32'h0000_0000);
      segs(3);
      txq.delete();
      rxq.delete();
      tx_send(3, 10);
      rx_send(2);
      segs(25);
      rx_cmp(10);
      // Strap off and a reset in mid-run: the port stays silent and captures nothing.
      strap <= 3'h0;
      rst <= 1'h1;
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      txq.delete();
      apb(1'h0, smii_pkg::ADDR_STAT, 32'h0000_0000);
      check("mode off", rd[8], 1'h0);
      tx_seg <= {8'h5a, 2'h2};
      segs(3);
      check("rx off", rx_last, 10'h000);
      check("tx off", txq.size(), 0);
      check("col off", col, 1'h0);
      close_out();
   end
endmodule : smii_phy_segment_port_bench
